//--- remote_io_link_pkg.sv
// Shared constants for the remote I/O link slave.
// Assumes a 20 MHz system clock and a byte-wide link front end on that clock.
`default_nettype none

package remote_io_link_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int DATA_W = 32;
  localparam int OFS_W = 5;
  localparam int FRAME_LEN = 10;
  localparam logic [3:0] IDX_HDR = 4'h0;
  localparam logic [3:0] IDX_TRUE_LAST = 4'h4;
  localparam logic [3:0] IDX_INV_LAST = 4'h8;
  localparam logic [3:0] IDX_CHECK = 4'h9;
  localparam int HDR_RUN_BIT = 7;
  localparam logic [4:0] IN_WORD_STEP = 5'h02;
  localparam int FIFO_DEPTH = 32;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LINK_TIMEOUT_MS = 20;
  localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;
endpackage : remote_io_link_pkg

`default_nettype wire

//--- link_fifo.sv
// Synchronous FIFO with a registered output stage.
// Assumes one clock; width and depth are parameters, depth a power of two.
`default_nettype none

module link_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (s_reg.count < CNT_W'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (s_reg.count != '0) && (!s_reg.out_valid || out_ready);
  assign out_valid = s_reg.out_valid;
  assign out_data = s_reg.out_data;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
      s_next.out_valid = 1'b1;
      s_next.out_data = mem[s_reg.rd_ptr];
    end else if (out_ready) begin
      s_next.out_valid = 1'b0;
    end
    s_next.count = s_reg.count + CNT_W'(push) - CNT_W'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
    if (push) begin
      mem[s_reg.wr_ptr] <= in_data;
    end
  end
endmodule : link_fifo

`default_nettype wire

//--- frame_check.sv
// Receive frame checker: header, true data, inverted data, check byte.
// Assumes bytes arrive as same-clock strobes; abort restarts the frame.
`default_nettype none

module frame_check (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic abort,
  output logic done,
  output logic good,
  output logic [7:0] hdr,
  output logic [31:0] data
);
  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] hdr;
    logic [31:0] tru;
    logic [31:0] inv;
    logic [7:0] block_check_character;
    logic done;
    logic good;
  } chk_state_t;

  chk_state_t s_reg;
  chk_state_t s_next;

  assign done = s_reg.done;
  assign good = s_reg.good;
  assign hdr = s_reg.hdr;
  assign data = s_reg.tru;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (abort) begin
      s_next.idx = remote_io_link_pkg::IDX_HDR;
    end else if (byte_valid) begin
      s_next.idx = s_reg.idx + 4'h1;
      s_next.block_check_character = s_reg.block_check_character ^ byte_data;
      if (s_reg.idx == remote_io_link_pkg::IDX_HDR) begin
        s_next.hdr = byte_data;
        s_next.block_check_character = byte_data;
      end else if (s_reg.idx <= remote_io_link_pkg::IDX_TRUE_LAST) begin
        s_next.tru = {s_reg.tru[23:0], byte_data};
      end else if (s_reg.idx <= remote_io_link_pkg::IDX_INV_LAST) begin
        s_next.inv = {s_reg.inv[23:0], byte_data};
      end else begin
        // Check byte plus true/inverted comparison
        s_next.done = 1'b1;
        s_next.good = (s_reg.block_check_character == byte_data)
          && (s_reg.tru == ~s_reg.inv);
        s_next.idx = remote_io_link_pkg::IDX_HDR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : frame_check

`default_nettype wire

//--- remote_io_link_slave.sv
// Slave end of a remote I/O link: indicators, word selection, output hold,
// frame checking and the reply stream toward the master.
// Assumes a byte-wide link front end on clk; switches arrive from pins.
// Operation
// - Ready lamp on while powered
// - Run lamp follows master operating mode
// - Error lamp steady on after link error
// - Lamp blinks normally, recovers without software
// - On error hold or clear master word
// - Switches select offset N, words N..N+3
// - Check byte and inverted copy compared
// - Exactly 32 bits each way per cycle
// - Host sees two words each direction
`default_nettype none

module remote_io_link_slave #(
  parameter int LINK_TIMEOUT_CYC = remote_io_link_pkg::LINK_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] word_sel_sw,
  input wire logic hold_clear_sw,
  input wire logic [15:0] host_word0,
  input wire logic [15:0] host_word1,
  output logic [15:0] master_word0,
  output logic [15:0] master_word1,
  input wire logic link_rx_valid,
  input wire logic [7:0] link_rx_data,
  input wire logic link_rx_err,
  output logic link_tx_valid,
  input wire logic link_tx_ready,
  output logic [7:0] link_tx_data,
  output logic led_ready,
  output logic led_run,
  output logic led_err
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [3:0] sw_meta;
    logic [3:0] sw_sync;
    logic [31:0] master_word;
    logic run;
    logic err;
    logic blink;
    logic ready;
    logic led_err;
    logic [remote_io_link_pkg::TIMER_W-1:0] timer;
    logic tx_busy;
    logic [3:0] tx_idx;
    logic [31:0] tx_data;
    logic [7:0] tx_check;
  } slave_state_t;

  slave_state_t s_reg;
  slave_state_t s_next;

  logic chk_done;
  logic chk_good;
  logic [7:0] chk_hdr;
  logic [31:0] chk_data;
  logic fifo_in_ready;
  logic [7:0] tx_byte;
  logic [4:0] ofs;
  logic accept;
  logic good_any;
  logic timeout;
  logic fault;
  logic push;

  // ****************************************
  // Frame checking and reply buffer
  // ****************************************
  frame_check u_check (
    .clk(clk),
    .rst_n(rst_n),
    .byte_valid(link_rx_valid),
    .byte_data(link_rx_data),
    .abort(link_rx_err),
    .done(chk_done),
    .good(chk_good),
    .hdr(chk_hdr),
    .data(chk_data)
  );

  link_fifo #(
    .WIDTH(remote_io_link_pkg::BYTE_W),
    .DEPTH(remote_io_link_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(s_reg.tx_busy),
    .in_ready(fifo_in_ready),
    .in_data(tx_byte),
    .out_valid(link_tx_valid),
    .out_ready(link_tx_ready),
    .out_data(link_tx_data)
  );

  // ****************************************
  // Decode
  // ****************************************
  assign ofs = {s_reg.sw_sync[2:0], 2'b00};
  assign good_any = chk_done && chk_good;
  assign accept = good_any && (chk_hdr[4:0] == ofs);
  assign timeout = (s_reg.timer == remote_io_link_pkg::TIMER_W'(LINK_TIMEOUT_CYC - 1));
  assign fault = (chk_done && !chk_good) || link_rx_err || timeout;
  assign push = s_reg.tx_busy && fifo_in_ready;

  // Reply byte: header, true words, inverted words, check byte
  always_comb begin
    tx_byte = s_reg.tx_check;
    if (s_reg.tx_idx == remote_io_link_pkg::IDX_HDR) begin
      tx_byte = {s_reg.run, 2'b00, ofs + remote_io_link_pkg::IN_WORD_STEP};
    end else if (s_reg.tx_idx <= remote_io_link_pkg::IDX_TRUE_LAST) begin
      tx_byte = s_reg.tx_data[31:24];
    end else if (s_reg.tx_idx <= remote_io_link_pkg::IDX_INV_LAST) begin
      tx_byte = ~s_reg.tx_data[31:24];
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.sw_meta = {hold_clear_sw, word_sel_sw};
    s_next.sw_sync = s_reg.sw_meta;
    s_next.ready = 1'b1;
    if (good_any || timeout) begin
      s_next.timer = '0;
    end else begin
      s_next.timer = s_reg.timer + 1'b1;
    end
    // Fault wins over a good frame in the same cycle
    if (fault) begin
      s_next.err = 1'b1;
      s_next.run = 1'b0;
      if (s_reg.sw_sync[3]) begin
        s_next.master_word = '0;
      end
    end else if (accept) begin
      s_next.err = 1'b0;
      s_next.blink = ~s_reg.blink;
      s_next.run = chk_hdr[remote_io_link_pkg::HDR_RUN_BIT];
      s_next.master_word = chk_data;
    end
    // A reply still queuing is not restarted
    if (accept && !fault && !s_reg.tx_busy) begin
      s_next.tx_busy = 1'b1;
      s_next.tx_idx = remote_io_link_pkg::IDX_HDR;
      s_next.tx_data = {host_word0, host_word1};
      s_next.tx_check = 8'h00;
    end else if (push) begin
      s_next.tx_idx = s_reg.tx_idx + 4'h1;
      s_next.tx_check = s_reg.tx_check ^ tx_byte;
      if (s_reg.tx_idx > remote_io_link_pkg::IDX_HDR) begin
        s_next.tx_data = {s_reg.tx_data[23:0], s_reg.tx_data[31:24]};
      end
      if (s_reg.tx_idx == remote_io_link_pkg::IDX_CHECK) begin
        s_next.tx_busy = 1'b0;
      end
    end
    s_next.led_err = s_next.err | s_next.blink;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign master_word0 = s_reg.master_word[31:16];
  assign master_word1 = s_reg.master_word[15:0];
  assign led_ready = s_reg.ready;
  assign led_run = s_reg.run;
  assign led_err = s_reg.led_err;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_READY_ON:
    assert property ($past(rst_n) |-> led_ready)
    else $error("ready lamp off while powered");

  AST_RUN_FOLLOWS:
    assert property (accept && !fault |=>
      led_run == $past(chk_hdr[remote_io_link_pkg::HDR_RUN_BIT]))
    else $error("run lamp does not follow master mode");

  AST_ERR_STEADY:
    assert property (fault |=> led_err && s_reg.err)
    else $error("error lamp not on after fault");

  AST_ERR_RECOVER:
    assert property (s_reg.err && accept && !fault |=> !s_reg.err)
    else $error("error not cleared by good cycle");

  AST_BLINK_TOGGLE:
    assert property (!s_reg.err && accept && !fault |=> led_err != $past(led_err))
    else $error("error lamp did not toggle on good cycle");

  AST_HOLD_CLEAR:
    assert property (fault && s_reg.sw_sync[3] |=> master_word0 == 16'h0000
      && master_word1 == 16'h0000)
    else $error("master word not cleared on fault");

  AST_HOLD_KEEP:
    assert property (fault && !s_reg.sw_sync[3] |=> $stable(master_word0)
      && $stable(master_word1))
    else $error("master word not held on fault");

  AST_OTHER_SLOT:
    assert property (good_any && !fault && chk_hdr[4:0] != ofs |=> $stable(master_word0))
    else $error("foreign slot frame changed master word");

  AST_WORD_LOAD:
    assert property (accept && !fault |=> {master_word0, master_word1} == $past(chk_data))
    else $error("accepted data not delivered");

  AST_REPLY_HDR:
    assert property (push && s_reg.tx_idx == remote_io_link_pkg::IDX_HDR |->
      tx_byte[4:0] == ofs + remote_io_link_pkg::IN_WORD_STEP)
    else $error("reply header carries wrong input slot");

  AST_REPLY_END:
    assert property (push && s_reg.tx_idx == remote_io_link_pkg::IDX_CHECK |=> !s_reg.tx_busy)
    else $error("reply longer than one frame");

  AST_ERR_HOLD:
    assert property (s_reg.err && !accept |=> led_err)
    else $error("error lamp not steady while error stands");

  AST_TIMEOUT_ERR:
    assert property (timeout |=> led_err && !led_run)
    else $error("link silence did not raise the error lamp");

  AST_LINE_ERR:
    assert property (link_rx_err |=> s_reg.err)
    else $error("line error did not set the error state");

  AST_BAD_CHECK:
    assert property (chk_done && !chk_good |=> s_reg.err)
    else $error("failed frame check did not set the error state");

  AST_RUN_CLEAR:
    assert property (fault |=> !led_run)
    else $error("run lamp stayed on after a link fault");

  AST_RUN_STABLE:
    assert property (!accept && !fault |=> $stable(led_run))
    else $error("run lamp changed without a master frame");

  AST_WORD_STABLE:
    assert property (!accept && !fault |=> $stable(master_word0)
      && $stable(master_word1))
    else $error("master words changed without a frame or fault");

  AST_BLINK_STEADY:
    assert property (!s_reg.err && !accept && !fault |=> $stable(led_err))
    else $error("error lamp changed between good cycles");

  AST_TX_HOLD:
    assert property (link_tx_valid && !link_tx_ready |=> link_tx_valid
      && $stable(link_tx_data))
    else $error("reply byte dropped or changed while stalled");

  AST_REPLY_LOAD:
    assert property (accept && !fault && !s_reg.tx_busy |=> s_reg.tx_data
      == {$past(host_word0), $past(host_word1)})
    else $error("reply does not carry the host words");

  AST_SLOT_SYNC:
    assert property ($past(rst_n, 2) |-> ofs == {$past(word_sel_sw, 2), 2'b00})
    else $error("slot offset does not follow the switches");

  AST_FOREIGN_QUIET:
    assert property (good_any && chk_hdr[4:0] != ofs && !s_reg.tx_busy
      |=> !s_reg.tx_busy)
    else $error("frame for another slot started a reply");

  COV_GOOD_CYCLE:
    cover property (accept ##[1:1000] accept);
  COV_ERR_RECOVER:
    cover property (fault ##[1:1000] (accept && !fault));
  COV_HOLD_CLEAR:
    cover property (fault && s_reg.sw_sync[3]);
  COV_REPLY_STALL:
    cover property (s_reg.tx_busy && !fifo_in_ready);
  COV_TIMEOUT:
    cover property (timeout);
endmodule : remote_io_link_slave

`default_nettype wire

//--- master_model.sv
// Behavioural remote bus master: sends frames byte by byte, drains replies.
// Assumes the bench calls send_frame; slow makes ready stall every other pair.
`default_nettype none

module master_model (
  input wire logic clk,
  output logic link_rx_valid,
  output logic [7:0] link_rx_data,
  output logic link_rx_err,
  input wire logic link_tx_valid,
  input wire logic [7:0] link_tx_data,
  output logic link_tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic slow = 1'b0;
  logic [7:0] rx_q[$];
  logic [3:0] ph = 4'h0;

  initial begin
    link_rx_valid = 1'b0;
    link_rx_data = 8'h00;
    link_rx_err = 1'b0;
    link_tx_ready = 1'b0;
  end

  always @(posedge clk) begin
    ph <= ph + 4'h1;
    link_tx_ready <= !slow || ph[1];
    if (link_tx_valid && link_tx_ready) begin
      rx_q.push_back(link_tx_data);
    end
  end

  // Fault 1 bad check byte, 2 bad inverse copy, 3 line error mid-frame
  task automatic send_frame(input logic run, input logic [4:0] n, input logic [31:0] d,
      input logic [1:0] f);
    logic [7:0] b[10];
    logic [7:0] x;
    b[0] = {run, 2'b00, n};
    for (int i = 0; i < 4; i++) begin
      b[1 + i] = d[31 - 8 * i -: 8];
      b[5 + i] = ~b[1 + i];
    end
    if (f == 2'h2) begin
      b[6] = b[6] ^ 8'h10;
    end
    x = 8'h00;
    for (int i = 0; i < 9; i++) begin
      x = x ^ b[i];
    end
    b[9] = (f == 2'h1) ? ~x : x;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      link_rx_valid <= !(f == 2'h3 && i == 5);
      link_rx_err <= (f == 2'h3 && i == 5);
      link_rx_data <= b[i];
      if (f == 2'h3 && i == 5) break;
    end
    @(posedge clk);
    link_rx_valid <= 1'b0;
    link_rx_err <= 1'b0;
    link_rx_data <= ~link_rx_data;
  endtask : send_frame
endmodule : master_model

`default_nettype wire

//--- testbench.sv
// Self-checking bench for the remote I/O link slave.
// Assumes master_model on the link; link timeout shortened to 200 cycles.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [2:0] sw; logic run; logic [31:0] d;} row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] word_sel_sw = 3'h0;
  logic hold_clear_sw = 1'b0;
  logic [15:0] host_word0 = 16'h0000;
  logic [15:0] host_word1 = 16'h0000;
  logic [15:0] master_word0, master_word1;
  logic link_rx_valid, link_rx_err, link_tx_valid, link_tx_ready;
  logic [7:0] link_rx_data, link_tx_data;
  logic led_ready, led_run, led_err;
  logic blink = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  row_t rows[8];

  always #25 clk = ~clk;

  remote_io_link_slave #(.LINK_TIMEOUT_CYC(200)) remote_io_link_slave_inst (.clk, .rst_n,
    .word_sel_sw, .hold_clear_sw, .host_word0, .host_word1, .master_word0, .master_word1,
    .link_rx_valid, .link_rx_data, .link_rx_err, .link_tx_valid, .link_tx_ready,
    .link_tx_data, .led_ready, .led_run, .led_err);

  master_model master_model_inst (.clk, .link_rx_valid, .link_rx_data, .link_rx_err,
    .link_tx_valid, .link_tx_data, .link_tx_ready);

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic frame(input logic run, input logic [4:0] n, input logic [31:0] d,
      input logic [1:0] f);
    master_model_inst.send_frame(run, n, d, f);
    repeat (4) @(posedge clk);
    #1;
  endtask : frame

  task automatic good(input logic run, input logic [31:0] d);
    logic [7:0] e[10];
    int k;
    frame(run, {word_sel_sw, 2'b00}, d, 2'h0);
    blink = ~blink;
    check("master_word0", master_word0, d[31:16]);
    check("master_word1", master_word1, d[15:0]);
    check("led_run", led_run, run);
    check("led_err", led_err, blink);
    e[0] = {run, 2'b00, {word_sel_sw, 2'b00} + 5'h02};
    {e[1], e[2], e[3], e[4]} = {host_word0, host_word1};
    e[9] = e[0];
    for (int i = 1; i < 5; i++) begin
      e[i + 4] = ~e[i];
    end
    k = 0;
    while (master_model_inst.rx_q.size() < 10 && k < 200) begin
      @(posedge clk);
      k++;
    end
    for (int i = 0; i < 10; i++) begin
      check("reply_byte", master_model_inst.rx_q[i], e[i]);
    end
    master_model_inst.rx_q.delete();
  endtask : good

  // ****************
  // Main sequence
  // ****************
  initial begin
    rows = '{'{3'h0, 1'b1, 32'h1234_5678}, '{3'h1, 1'b0, 32'h9ABC_DEF0},
      '{3'h2, 1'b1, 32'hFFFF_0000}, '{3'h3, 1'b0, 32'h0001_8000},
      '{3'h4, 1'b1, 32'h55AA_AA55}, '{3'h5, 1'b1, 32'h0F0F_F0F0},
      '{3'h6, 1'b0, 32'h8421_1248}, '{3'h7, 1'b1, 32'hC3C3_3C3C}};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("led_ready", led_ready, 1'b1);
    check("led_err", led_err, 1'b0);
    foreach (rows[r]) begin
      @(posedge clk);
      word_sel_sw <= rows[r].sw;
      host_word0 <= ~rows[r].d[31:16];
      host_word1 <= rows[r].d[15:0] ^ 16'h0F0F;
      master_model_inst.slow = r[0];
      repeat (3) @(posedge clk);
      good(rows[r].run, rows[r].d);
    end
    frame(1'b1, 5'h00, 32'hDEAD_BEEF, 2'h0);
    check("master_word0", master_word0, rows[7].d[31:16]);
    repeat (16) @(posedge clk);
    #1;
    check("reply_count", master_model_inst.rx_q.size(), 0);
    frame(1'b1, 5'h1C, 32'hCAFE_F00D, 2'h1);
    check("led_err", led_err, 1'b1);
    check("master_word0", master_word0, rows[7].d[31:16]);
    good(1'b1, 32'hA5A5_5A5A);
    @(posedge clk);
    hold_clear_sw <= 1'b1;
    repeat (3) @(posedge clk);
    frame(1'b1, 5'h1C, 32'h0F0F_F0F0, 2'h2);
    check("master_word0", master_word0, 16'h0000);
    check("master_word1", master_word1, 16'h0000);
    good(1'b0, 32'h1111_2222);
    frame(1'b1, 5'h1C, 32'h3333_4444, 2'h3);
    check("led_err", led_err, 1'b1);
    check("master_word1", master_word1, 16'h0000);
    good(1'b1, 32'h5555_6666);
    repeat (220) @(posedge clk);
    #1;
    check("led_err", led_err, 1'b1);
    check("led_run", led_run, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("led_ready", led_ready, 1'b0);
    check("master_word0", master_word0, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    blink = 1'b0;
    repeat (4) @(posedge clk);
    good(1'b1, 32'h7777_8888);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
